// *** timer16_pkg.sv ***
package timer16_pkg;

  localparam logic [11:0] ADDR_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_COUNT    = 12'h004;
  localparam logic [11:0] ADDR_COMPARE_A = 12'h008;
  localparam logic [11:0] ADDR_COMPARE_B = 12'h00C;
  localparam logic [11:0] ADDR_CAPTURE  = 12'h010;
  localparam logic [11:0] ADDR_FLAGS    = 12'h014;

  localparam int CTL_MODE_LSB  = 0;
  localparam int CTL_ACT_A_LSB = 4;
  localparam int CTL_ACT_B_LSB = 6;
  localparam int CTL_DIR_A_BIT = 8;
  localparam int CTL_DIR_B_BIT = 9;

  localparam int FLG_OVF_BIT = 0;
  localparam int FLG_CMPA_BIT = 1;
  localparam int FLG_CMPB_BIT = 2;
  localparam int FLG_CAP_BIT = 3;

  localparam logic [3:0] MODE_CTC_A   = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST8   = 4'h5;
  localparam logic [3:0] MODE_FAST9   = 4'h6;
  localparam logic [3:0] MODE_FAST10  = 4'h7;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A  = 4'hF;

  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_PWM_INV = 2'h2;
  localparam logic [1:0] ACT_PWM_NON = 2'h3;

  localparam logic [15:0] TOP_FIX8  = 16'h00FF;
  localparam logic [15:0] TOP_FIX9  = 16'h01FF;
  localparam logic [15:0] TOP_FIX10 = 16'h03FF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] BOTTOM    = 16'h0000;
  localparam logic [15:0] RESET_16  = 16'h0000;
  localparam logic [31:0] RESET_32  = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] action;
    logic [15:0] value;
    logic        buffered;
  } compare_cfg_t;

  typedef struct packed {
    logic match;
    logic at_top;
    logic at_bottom;
  } compare_evt_t;

  function automatic logic is_fast(input logic [3:0] mode);
    return (mode == MODE_FAST8) || (mode == MODE_FAST9) || (mode == MODE_FAST10) ||
           (mode == MODE_FAST_CAP) || (mode == MODE_FAST_A);
  endfunction

  function automatic logic [15:0] fixed_mask(input logic [3:0] mode);
    unique case (mode)
      MODE_FAST8:  return TOP_FIX8;
      MODE_FAST9:  return TOP_FIX9;
      MODE_FAST10: return TOP_FIX10;
      default:     return COUNT_MAX;
    endcase
  endfunction

endpackage

// *** compare_output_unit.sv ***
`timescale 1ns/1ps
module compare_output_unit (
  input  wire logic                       clock_in,
  input  wire logic                       rstn_in,
  input  wire logic                       ce_in,
  input  wire logic [3:0]                 mode_in,
  input  wire timer16_pkg::compare_cfg_t  cfg_in,
  input  wire timer16_pkg::compare_evt_t  evt_in,
  input  wire logic                       is_a_in,
  output logic                            state_out
);
  import timer16_pkg::*;

  logic fast;
  assign fast = is_fast(mode_in);

  // The internal state runs regardless of the pin direction bit.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_out <= 1'b0;
    end else if (ce_in) begin
      if (fast) begin
        unique case (cfg_in.action)
          ACT_TOGGLE: begin
            if (is_a_in && mode_in == MODE_FAST_A && evt_in.match) begin
              state_out <= ~state_out;
            end
          end
          ACT_PWM_INV: begin
            // Match wins over BOTTOM so compare 0 keeps a spike, TOP stays constant.
            if (evt_in.match) begin
              state_out <= 1'b1;
            end else if (evt_in.at_bottom) begin
              state_out <= 1'b0;
            end
          end
          ACT_PWM_NON: begin
            if (evt_in.match) begin
              state_out <= 1'b0;
            end else if (evt_in.at_bottom) begin
              state_out <= 1'b1;
            end
          end
          ACT_NONE: begin
          end
        endcase
      end else if (cfg_in.action == ACT_TOGGLE && evt_in.match) begin
        state_out <= ~state_out;
      end
    end
  end

endmodule

// *** timer16_ctc_fast_pwm.sv ***
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module timer16_ctc_fast_pwm (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        timer_tick_in,
  input  wire logic        cmpa_ack_in,
  input  wire logic        cap_ack_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pin_a_out,
  output logic             pin_a_oe_out,
  output logic             pin_b_out,
  output logic             pin_b_oe_out
);
  import timer16_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] control_r;
  logic [15:0] count_value_r;
  logic [15:0] compare_a_value_r;
  logic [15:0] compare_a_buf_r;
  logic [15:0] compare_b_value_r;
  logic [15:0] compare_b_buf_r;
  logic [15:0] capture_top_value_r;
  logic [3:0]  timer_flag_reg_r;
  logic [1:0]  match_d_r;
  logic [1:0]  oc_state;

  logic [3:0]  waveform_mode_sel;
  logic [1:0]  output_action_a_sel;
  logic [1:0]  output_action_b_sel;
  logic        fast;
  logic [15:0] top_value;
  logic        at_top;
  logic        top_is_a;
  logic        top_is_cap;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] wmask;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;

  assign waveform_mode_sel   = control_r[CTL_MODE_LSB +: 4];
  assign output_action_a_sel = control_r[CTL_ACT_A_LSB +: 2];
  assign output_action_b_sel = control_r[CTL_ACT_B_LSB +: 2];
  assign fast  = is_fast(waveform_mode_sel);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wmask = fixed_mask(waveform_mode_sel);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    top_is_a   = 1'b0;
    top_is_cap = 1'b0;
    top_value  = COUNT_MAX;
    unique case (waveform_mode_sel)
      MODE_CTC_A: begin
        top_value = compare_a_value_r;
        top_is_a  = 1'b1;
      end
      MODE_CTC_CAP: begin
        top_value  = capture_top_value_r;
        top_is_cap = 1'b1;
      end
      MODE_FAST8:    top_value = TOP_FIX8;
      MODE_FAST9:    top_value = TOP_FIX9;
      MODE_FAST10:   top_value = TOP_FIX10;
      MODE_FAST_CAP: begin
        top_value  = capture_top_value_r;
        top_is_cap = 1'b1;
      end
      MODE_FAST_A: begin
        top_value = compare_a_value_r;
        top_is_a  = 1'b1;
      end
      default: top_value = COUNT_MAX;
    endcase
  end

  assign at_top = (count_value_r == top_value);

  ////////////////////////////////////////////////////////////////////////////////
  // Single-slope up count: equality with TOP clears on the next tick, a missed
  // TOP runs on to the maximum and wraps through zero.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_value_r <= RESET_16;
    end else if (ce_in) begin
      if (wr_en && paddr == ADDR_COUNT) begin
        count_value_r <= pwdata[15:0];
      end else if (timer_tick_in) begin
        if (at_top) begin
          count_value_r <= BOTTOM;
        end else begin
          count_value_r <= 16'(count_value_r + 16'h0001);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare writes go to the buffer; outside fast PWM the buffer is transparent.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      compare_a_buf_r   <= RESET_16;
      compare_b_buf_r   <= RESET_16;
      compare_a_value_r <= RESET_16;
      compare_b_value_r <= RESET_16;
    end else if (ce_in) begin
      if (wr_en && paddr == ADDR_COMPARE_A) begin
        compare_a_buf_r <= pwdata[15:0] & wmask;
      end
      if (wr_en && paddr == ADDR_COMPARE_B) begin
        compare_b_buf_r <= pwdata[15:0] & wmask;
      end
      if (!fast) begin
        if (wr_en && paddr == ADDR_COMPARE_A) begin
          compare_a_value_r <= pwdata[15:0] & wmask;
        end
        if (wr_en && paddr == ADDR_COMPARE_B) begin
          compare_b_value_r <= pwdata[15:0] & wmask;
        end
      end else if (timer_tick_in && at_top) begin
        compare_a_value_r <= compare_a_buf_r;
        compare_b_value_r <= compare_b_buf_r;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      capture_top_value_r <= RESET_16;
    end else if (ce_in && wr_en && paddr == ADDR_CAPTURE) begin
      capture_top_value_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      control_r <= RESET_32;
    end else if (ce_in && wr_en && paddr == ADDR_CONTROL) begin
      control_r <= {22'h000000, pwdata[9:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Match is registered so the compare flag lands one clock cycle after the tick.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      match_d_r <= 2'h0;
    end else if (ce_in && timer_tick_in) begin
      match_d_r[0] <= (count_value_r == compare_a_value_r) && !(fast && top_is_a);
      match_d_r[1] <= (count_value_r == compare_b_value_r);
    end else if (ce_in) begin
      match_d_r <= 2'h0;
    end
  end

  always_comb begin
    flag_set = 4'h0;
    if (timer_tick_in) begin
      if (fast) begin
        flag_set[FLG_OVF_BIT]  = at_top;
        flag_set[FLG_CMPA_BIT] = at_top && top_is_a;
        flag_set[FLG_CAP_BIT]  = at_top && top_is_cap;
      end else begin
        flag_set[FLG_OVF_BIT] = (count_value_r == COUNT_MAX);
        flag_set[FLG_CAP_BIT] = at_top && top_is_cap;
      end
    end
    flag_set[FLG_CMPA_BIT] = flag_set[FLG_CMPA_BIT] | match_d_r[0];
    flag_set[FLG_CMPB_BIT] = match_d_r[1];
  end

  always_comb begin
    flag_clr = 4'h0;
    if (wr_en && paddr == ADDR_FLAGS) begin
      flag_clr = pwdata[3:0];
    end
    flag_clr[FLG_CMPA_BIT] = flag_clr[FLG_CMPA_BIT] | cmpa_ack_in;
    flag_clr[FLG_CAP_BIT]  = flag_clr[FLG_CAP_BIT] | cap_ack_in;
  end

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_flag_reg_r <= 4'h0;
    end else if (ce_in) begin
      timer_flag_reg_r <= (timer_flag_reg_r & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_unit
      compare_cfg_t cfg;
      compare_evt_t evt;
      assign cfg.action   = (gi == 0) ? output_action_a_sel : output_action_b_sel;
      assign cfg.value    = (gi == 0) ? compare_a_value_r : compare_b_value_r;
      assign cfg.buffered = fast;
      assign evt.match    = timer_tick_in &&
                            (count_value_r == cfg.value) && !(fast && gi == 0 && top_is_a
                            && cfg.action != ACT_TOGGLE);
      assign evt.at_top    = timer_tick_in && at_top;
      assign evt.at_bottom = timer_tick_in && at_top;
      compare_output_unit u_unit (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .ce_in     (ce_in),
        .mode_in   (waveform_mode_sel),
        .cfg_in    (cfg),
        .evt_in    (evt),
        .is_a_in   (gi == 0),
        .state_out (oc_state[gi])
      );
    end
  endgenerate

  // The pin follows the internal state only while its direction bit is set.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_a_out    <= 1'b0;
      pin_a_oe_out <= 1'b0;
      pin_b_out    <= 1'b0;
      pin_b_oe_out <= 1'b0;
    end else if (ce_in) begin
      pin_a_oe_out <= control_r[CTL_DIR_A_BIT];
      pin_a_out    <= oc_state[0] & control_r[CTL_DIR_A_BIT];
      pin_b_oe_out <= control_r[CTL_DIR_B_BIT];
      pin_b_out    <= oc_state[1] & control_r[CTL_DIR_B_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB: zero wait states, unmapped reads return zero with an error.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata  <= RESET_32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce_in) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= RESET_32;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_CONTROL:   prdata <= control_r;
          ADDR_COUNT:     prdata <= {16'h0000, count_value_r};
          ADDR_COMPARE_A: prdata <= {16'h0000, compare_a_buf_r};
          ADDR_COMPARE_B: prdata <= {16'h0000, compare_b_buf_r};
          ADDR_CAPTURE:   prdata <= {16'h0000, capture_top_value_r};
          ADDR_FLAGS:     prdata <= {28'h0000000, timer_flag_reg_r};
          default:        pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        pslverr <= !(paddr inside {ADDR_CONTROL, ADDR_COUNT, ADDR_COMPARE_A,
                                   ADDR_COMPARE_B, ADDR_CAPTURE, ADDR_FLAGS});
      end
    end
  end

endmodule

// *** pin_load.sv ***
`timescale 1ns/1ps
module pin_load (
  input  wire logic drive_in,
  input  wire logic enable_in,
  output logic      level_out
);
  // A weak pull-down holds the pad low whenever the timer does not drive it.
  assign level_out = enable_in ? drive_in : 1'b0;
endmodule

// *** timer16_chk.sv ***
`timescale 1ns/1ps
module timer16_chk (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        pin_a_out,
  input  wire logic        pin_a_oe_out,
  input  wire logic        pin_b_out,
  input  wire logic        pin_b_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////
  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_needs_setup: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_one_cycle: assert property ($rose(pready) |=> $fell(pready))
    else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_error_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_mapped_no_error: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("mapped access refused");
  a_upper_half_zero: assert property (pready && !pwrite && paddr inside {12'h004, 12'h008,
    12'h00C, 12'h010} |-> prdata[31:16] == 16'h0)
    else $error("upper half not zero");
  a_pin_a_gated: assert property (pin_a_out |-> pin_a_oe_out)
    else $error("pin a shown while input");
  a_pin_b_gated: assert property (pin_b_out |-> pin_b_oe_out)
    else $error("pin b shown while input");
endmodule
bind timer16_ctc_fast_pwm timer16_chk chk_i (
  .clock_in(clock_in), .rstn_in(rstn_in), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_a_out(pin_a_out), .pin_a_oe_out(pin_a_oe_out), .pin_b_out(pin_b_out),
  .pin_b_oe_out(pin_b_oe_out)
);

// *** timer16_ctc_fast_pwm_tb_top.sv ***
`timescale 1ns/1ps
module timer16_ctc_fast_pwm_tb_top;
  import timer16_pkg::*;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] val;} note_t;
  logic        clock_in, rstn_in, timer_tick_in, cmpa_ack_in, cap_ack_in, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pin_a_out, pin_a_oe_out, pin_b_out, pin_b_oe_out;
  logic        lvl_a, lvl_b;
  int          n_errors = 0;
  int          tests_run = 0;
  int          c, top;
  note_t       q[$];
  note_t       nt;
  timer16_ctc_fast_pwm DUT (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .timer_tick_in(timer_tick_in), .cmpa_ack_in(cmpa_ack_in), .cap_ack_in(cap_ack_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_a_out(pin_a_out),
    .pin_a_oe_out(pin_a_oe_out), .pin_b_out(pin_b_out), .pin_b_oe_out(pin_b_oe_out));
  pin_load la (.drive_in(pin_a_out), .enable_in(pin_a_oe_out), .level_out(lvl_a));
  pin_load lb (.drive_in(pin_b_out), .enable_in(pin_b_oe_out), .level_out(lvl_b));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The note is queued before the request so the monitor always finds it.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input logic er);
    int k = 0;
    q.push_back('{er, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      $display("ERROR %0t: bus hung", $time);
      give_verdict();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_in);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, m, e, 1'b0);
  endtask
  task automatic tk(input int n);
    timer_tick_in <= 1'b1;
    repeat (n) @(posedge clock_in);
    timer_tick_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    if (pready === 1'b1) begin
      nt = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, nt.err});
      chk(prdata & nt.mask, nt.val);
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rstn_in = 1'b0;
    timer_tick_in = 1'b0;
    cmpa_ack_in = 1'b0;
    cap_ack_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'h5E18786F));
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 24; a += 4) rd(12'(a), '1, 32'h0);
    bus(1'b1, 12'h018, $urandom, 32'h0, 32'h0, 1'b1);
    bus(1'b0, 12'h020, 32'h0, '1, 32'h0, 1'b1);
    top = 2 + $urandom % 6;
    wr(ADDR_COMPARE_A, top);
    wr(ADDR_CONTROL, 32'h114);
    tk(top + 2);
    rd(ADDR_COUNT, '1, 32'h1);
    chk(lvl_a, 32'h1);
    rd(ADDR_FLAGS, 32'hB, 32'h2);
    wr(ADDR_FLAGS, 32'h2);
    rd(ADDR_FLAGS, 32'h2, 32'h0);
    tk(top + 1);
    chk(lvl_a, 32'h0);
    cmpa_ack_in <= 1'b1;
    @(posedge clock_in);
    cmpa_ack_in <= 1'b0;
    @(posedge clock_in);
    rd(ADDR_FLAGS, 32'h2, 32'h0);
    wr(ADDR_CONTROL, 32'h014);
    tk(top + 1);
    chk(pin_a_oe_out, 32'h0);
    chk(lvl_a, 32'h0);
    wr(ADDR_CONTROL, 32'h114);
    repeat (2) @(posedge clock_in);
    chk(lvl_a, 32'h1);
    // A top below the count forces a full wrap; this is the long stretch of the run.
    wr(ADDR_COMPARE_A, 32'h0);
    tk(65535);
    rd(ADDR_COUNT, '1, 32'h0);
    rd(ADDR_FLAGS, 32'h1, 32'h1);
    for (int i = 0; i < 3; i++) begin
      top = (256 << i) - 1;
      wr(ADDR_FLAGS, 32'hF);
      wr(ADDR_CONTROL, 5 + i);
      tk(top);
      rd(ADDR_COUNT, '1, top);
      tk(1);
      rd(ADDR_COUNT, '1, 32'h0);
      rd(ADDR_FLAGS, 32'h1, 32'h1);
    end
    wr(ADDR_CONTROL, 32'h2C5);
    wr(ADDR_COMPARE_B, 32'h1234);
    rd(ADDR_COMPARE_B, '1, 32'h34);
    wr(ADDR_COMPARE_A, 32'h80);
    c = 0;
    for (int act = 3; act >= 2; act--) begin
      wr(ADDR_CONTROL, 32'h205 | (act << 6));
      tk(32'h110 - c);
      chk(lvl_b, act == 3);
      tk(32'h30);
      chk(lvl_b, act == 2);
      c = 32'h40;
    end
    wr(ADDR_CONTROL, 32'h11F);
    wr(ADDR_FLAGS, 32'hF);
    tk(32'h40);
    wr(ADDR_COMPARE_A, 32'h20);
    rd(ADDR_COUNT, '1, 32'h80);
    tk(1);
    rd(ADDR_FLAGS, 32'h3, 32'h3);
    chk(lvl_a, 32'h0);
    tk(32'h21);
    rd(ADDR_COUNT, '1, 32'h0);
    chk(lvl_a, 32'h1);
    wr(ADDR_CAPTURE, 32'h5);
    wr(ADDR_CONTROL, 32'h00E);
    wr(ADDR_FLAGS, 32'hF);
    tk(6);
    rd(ADDR_COUNT, '1, 32'h0);
    rd(ADDR_FLAGS, 32'h9, 32'h9);
    cap_ack_in <= 1'b1;
    @(posedge clock_in);
    cap_ack_in <= 1'b0;
    @(posedge clock_in);
    rd(ADDR_FLAGS, 32'h9, 32'h1);
    give_verdict();
  end
endmodule
